// [rtl/pic_filter.sv]
// Tag filtering and user priority ceiling for one ingress frame.
`timescale 1ns/1ps
module pic_filter
    import pic_pkg::*;
(
    input wire logic [7:0] flt_i,
    input wire logic tagged_i,
    input wire logic [2:0] uprio_i,
    input wire logic [2:0] def_uprio_i,
    output logic drop_o,
    output logic [2:0] uprio_o
);
    always_comb begin
        drop_o = (flt_i[PIC_FLT_UNTAG] & ~tagged_i) | (flt_i[PIC_FLT_TAG] & tagged_i);
        uprio_o = uprio_i;
        if (flt_i[PIC_FLT_CEIL] && uprio_i > def_uprio_i) begin
            uprio_o = def_uprio_i;
        end
    end
endmodule : pic_filter

// [rtl/pic_pkg.sv]
// Constants shared by the per-port ingress control bank.
package pic_pkg;
    // ----------------------------------------
    // Geometry
    // ----------------------------------------
    localparam int unsigned PIC_FIRST_PORT = 1;
    localparam int unsigned PIC_LAST_PORT = 7;
    localparam int unsigned PIC_NSRC = 6;
    // ----------------------------------------
    // Register indices inside a port region
    // ----------------------------------------
    localparam logic [11:0] PIC_IDX_MIRROR = 12'h800;
    localparam logic [11:0] PIC_IDX_PRIO = 12'h801;
    localparam logic [11:0] PIC_IDX_FILTER = 12'h802;
    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int unsigned PIC_MIR_RX = 6;
    localparam int unsigned PIC_MIR_TX = 5;
    localparam int unsigned PIC_MIR_SNIFF = 1;
    localparam int unsigned PIC_PRI_HIGH = 7;
    localparam int unsigned PIC_PRI_OR = 6;
    localparam int unsigned PIC_PRI_MAC = 4;
    localparam int unsigned PIC_PRI_VLAN = 3;
    localparam int unsigned PIC_PRI_DOT1P = 2;
    localparam int unsigned PIC_PRI_DSCP = 1;
    localparam int unsigned PIC_PRI_ACL = 0;
    localparam int unsigned PIC_FLT_CEIL = 7;
    localparam int unsigned PIC_FLT_UNTAG = 4;
    localparam int unsigned PIC_FLT_TAG = 3;
    localparam int unsigned PIC_FLT_DEFP_LSB = 0;
    // ----------------------------------------
    // Writable bit masks and reset values
    // ----------------------------------------
    localparam logic [7:0] PIC_MIR_MASK = 8'h62;
    localparam logic [7:0] PIC_PRI_MASK = 8'hDF;
    localparam logic [7:0] PIC_FLT_MASK = 8'h9F;
    localparam logic [7:0] PIC_REG_RST = 8'h00;
    // ----------------------------------------
    // Candidate order of the priority sources
    // ----------------------------------------
    typedef enum logic [2:0] {
        PIC_SRC_ACL = 3'h0,
        PIC_SRC_MAC = 3'h1,
        PIC_SRC_VLAN = 3'h2,
        PIC_SRC_DSCP = 3'h3,
        PIC_SRC_DOT1P = 3'h4,
        PIC_SRC_DEF = 3'h5
    } pic_src_t;
endpackage : pic_pkg

// [rtl/pic_prio_sel.sv]
// Combines the enabled classification results into one frame priority.
`timescale 1ns/1ps
module pic_prio_sel
    import pic_pkg::*;
(
    input wire logic [7:0] sel_i,
    input wire logic [2:0] def_prio_i,
    input wire logic [PIC_NSRC-2:0] vld_i,
    input wire logic [3*(PIC_NSRC-1)-1:0] prio_i,
    output logic [2:0] prio_o
);
    logic [PIC_NSRC-1:0] cand;
    logic [2:0] val [PIC_NSRC];
    logic [PIC_NSRC-2:0] en;
    logic found;

    always_comb begin
        en = '0;
        en[PIC_SRC_ACL] = sel_i[PIC_PRI_ACL];
        en[PIC_SRC_MAC] = sel_i[PIC_PRI_MAC];
        en[PIC_SRC_VLAN] = sel_i[PIC_PRI_VLAN];
        en[PIC_SRC_DSCP] = sel_i[PIC_PRI_DSCP];
        en[PIC_SRC_DOT1P] = sel_i[PIC_PRI_DOT1P];
        for (int i = 0; i < PIC_NSRC - 1; i++) begin
            cand[i] = en[i] & vld_i[i];
            val[i] = prio_i[3*i +: 3];
        end
        // The default joins when VLAN, Diffserv and 802.1p give nothing.
        cand[PIC_SRC_DEF] = ~(cand[PIC_SRC_VLAN] | cand[PIC_SRC_DSCP] | cand[PIC_SRC_DOT1P]);
        val[PIC_SRC_DEF] = def_prio_i;
        prio_o = 3'h0;
        found = 1'b0;
        if (sel_i[PIC_PRI_HIGH]) begin
            for (int i = 0; i < PIC_NSRC; i++) begin
                if (cand[i] && val[i] > prio_o) begin
                    prio_o = val[i];
                end
            end
        end else if (sel_i[PIC_PRI_OR]) begin
            for (int i = 0; i < PIC_NSRC; i++) begin
                if (cand[i]) begin
                    prio_o = prio_o | val[i];
                end
            end
        end else begin
            for (int i = 0; i < PIC_NSRC; i++) begin
                if (cand[i] && !found) begin
                    prio_o = val[i];
                    found = 1'b1;
                end
            end
        end
    end
endmodule : pic_prio_sel

// [rtl/pic_top.sv]
// Per-port ingress control bank with a classic Wishbone register slave.
//
// What this block does
// - One bank per port 1 to 7; port number is the high address nibble.
// - Receive monitor bit marks every received frame monitored, copied to sniffer.
// - Transmit monitor bit marks every transmitted frame monitored, copied to sniffer.
// - Sniffer bit makes the port transmit all monitored frames.
// - Port mirroring bits act only together with the switch-wide mirroring enable.
// - Highest mode picks the largest priority among enabled sources.
// - OR mode forms priority as bitwise OR of all available results.
// - MAC address classification enable.
// - VLAN classification enable.
// - 802.1p tag priority classification enable.
// - Diffserv classification enable.
// - ACL priority classification enable.
// - Ceiling clamps user priority above the port default tag priority.
// - Drop-untagged bit discards frames without an 802.1Q tag.
// - Drop-tagged bit discards frames carrying an 802.1Q tag.
// - Without VLAN, Diffserv or 802.1p result, use 3-bit default priority.
//
// Local design decision: the Wishbone register port.
`timescale 1ns/1ps
module pic_top
    import pic_pkg::*;
#(
    parameter int unsigned ADR_W = 18
) (
    input wire logic CLK_I,
    input wire logic RSTN_I,
    // Wishbone slave.
    input wire logic CYC_I,
    input wire logic STB_I,
    input wire logic WE_I,
    input wire logic [ADR_W-1:2] ADR_I,
    input wire logic [3:0] SEL_I,
    input wire logic [31:0] DAT_I,
    output logic [31:0] DAT_O,
    output logic ACK_O,
    // Switch-wide mirroring enable.
    input wire logic MIRROR_GLOBAL_EN_I,
    // Ingress frame descriptor.
    input wire logic FRM_VALID_I,
    input wire logic [2:0] FRM_PORT_I,
    input wire logic FRM_TAGGED_I,
    input wire logic [2:0] FRM_UPRIO_I,
    input wire logic [2:0] FRM_DEF_UPRIO_I,
    input wire logic FRM_MAC_VLD_I,
    input wire logic [2:0] FRM_MAC_PRIO_I,
    input wire logic FRM_VLAN_VLD_I,
    input wire logic [2:0] FRM_VLAN_PRIO_I,
    input wire logic FRM_DSCP_VLD_I,
    input wire logic [2:0] FRM_DSCP_PRIO_I,
    input wire logic FRM_ACL_VLD_I,
    input wire logic [2:0] FRM_ACL_PRIO_I,
    // Egress frame event.
    input wire logic TX_VALID_I,
    input wire logic [2:0] TX_PORT_I,
    // Results.
    output logic FRM_VALID_O,
    output logic FRM_DROP_O,
    output logic [2:0] FRM_PRIO_O,
    output logic [2:0] FRM_UPRIO_O,
    output logic FRM_MON_O,
    output logic TX_VALID_O,
    output logic TX_MON_O,
    output logic [6:0] SNIFF_PORTS_O,
    output logic [6:0] RX_MON_PORTS_O,
    output logic [6:0] TX_MON_PORTS_O
);
    // ----------------------------------------
    // Storage
    // ----------------------------------------
    logic [7:0] mir_q [PIC_FIRST_PORT:PIC_LAST_PORT];
    logic [7:0] pri_q [PIC_FIRST_PORT:PIC_LAST_PORT];
    logic [7:0] flt_q [PIC_FIRST_PORT:PIC_LAST_PORT];
    logic ack_q;
    logic [31:0] dat_q;

    function automatic logic port_ok(input logic [3:0] p);
        port_ok = (p >= 4'(PIC_FIRST_PORT)) && (p <= 4'(PIC_LAST_PORT));
    endfunction : port_ok

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    logic [3:0] bus_port;
    logic [11:0] bus_idx;
    logic bus_req;
    logic bus_wr;
    logic hit_mir;
    logic hit_pri;
    logic hit_flt;

    assign bus_port = ADR_I[ADR_W-1:ADR_W-4];
    assign bus_idx = ADR_I[13:2];
    assign bus_req = CYC_I & STB_I & ~ack_q;
    assign bus_wr = bus_req & WE_I & SEL_I[0];
    assign hit_mir = port_ok(bus_port) && (bus_idx == PIC_IDX_MIRROR);
    assign hit_pri = port_ok(bus_port) && (bus_idx == PIC_IDX_PRIO);
    assign hit_flt = port_ok(bus_port) && (bus_idx == PIC_IDX_FILTER);

    // ----------------------------------------
    // Register writes
    // ----------------------------------------
    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            for (int p = PIC_FIRST_PORT; p <= PIC_LAST_PORT; p++) begin
                mir_q[p] <= PIC_REG_RST;
                pri_q[p] <= PIC_REG_RST;
                flt_q[p] <= PIC_REG_RST;
            end
        end else if (bus_wr) begin
            for (int p = PIC_FIRST_PORT; p <= PIC_LAST_PORT; p++) begin
                if (bus_port == 4'(p)) begin
                    if (hit_mir) begin
                        mir_q[p] <= DAT_I[7:0] & PIC_MIR_MASK;
                    end
                    if (hit_pri) begin
                        pri_q[p] <= DAT_I[7:0] & PIC_PRI_MASK;
                    end
                    if (hit_flt) begin
                        flt_q[p] <= DAT_I[7:0] & PIC_FLT_MASK;
                    end
                end
            end
        end
    end

    // ----------------------------------------
    // Bus answer
    // ----------------------------------------
    // Every access, mapped or not, is acknowledged one cycle later; unmapped ones read zero.
    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= bus_req;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            dat_q <= 32'h0000_0000;
        end else if (bus_req) begin
            dat_q <= 32'h0000_0000;
            for (int p = PIC_FIRST_PORT; p <= PIC_LAST_PORT; p++) begin
                if (bus_port == 4'(p)) begin
                    if (hit_mir) begin
                        dat_q <= {24'h00_0000, mir_q[p]};
                    end
                    if (hit_pri) begin
                        dat_q <= {24'h00_0000, pri_q[p]};
                    end
                    if (hit_flt) begin
                        dat_q <= {24'h00_0000, flt_q[p]};
                    end
                end
            end
        end
    end

    assign ACK_O = ack_q;
    assign DAT_O = dat_q;

    // ----------------------------------------
    // Configuration of the frame's port
    // ----------------------------------------
    logic [7:0] f_mir;
    logic [7:0] f_pri;
    logic [7:0] f_flt;
    logic [7:0] t_mir;

    always_comb begin
        f_mir = 8'h00;
        f_pri = 8'h00;
        f_flt = 8'h00;
        t_mir = 8'h00;
        for (int p = PIC_FIRST_PORT; p <= PIC_LAST_PORT; p++) begin
            if (FRM_PORT_I == 3'(p)) begin
                f_mir = mir_q[p];
                f_pri = pri_q[p];
                f_flt = flt_q[p];
            end
            if (TX_PORT_I == 3'(p)) begin
                t_mir = mir_q[p];
            end
        end
    end

    // ----------------------------------------
    // Classification and filtering
    // ----------------------------------------
    logic [2:0] prio_d;
    logic drop_d;
    logic [2:0] uprio_d;
    logic [PIC_NSRC-2:0] src_vld;
    logic [3*(PIC_NSRC-1)-1:0] src_prio;

    // The 802.1p result exists only for tagged frames.
    assign src_vld = {FRM_TAGGED_I, FRM_DSCP_VLD_I, FRM_VLAN_VLD_I, FRM_MAC_VLD_I, FRM_ACL_VLD_I};
    assign src_prio = {FRM_UPRIO_I, FRM_DSCP_PRIO_I, FRM_VLAN_PRIO_I, FRM_MAC_PRIO_I, FRM_ACL_PRIO_I};

    pic_prio_sel u_prio (
        .sel_i(f_pri),
        .def_prio_i(f_flt[PIC_FLT_DEFP_LSB +: 3]),
        .vld_i(src_vld),
        .prio_i(src_prio),
        .prio_o(prio_d)
    );

    pic_filter u_filter (
        .flt_i(f_flt),
        .tagged_i(FRM_TAGGED_I),
        .uprio_i(FRM_UPRIO_I),
        .def_uprio_i(FRM_DEF_UPRIO_I),
        .drop_o(drop_d),
        .uprio_o(uprio_d)
    );

    // ----------------------------------------
    // Frame results
    // ----------------------------------------
    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            FRM_VALID_O <= 1'b0;
            FRM_DROP_O <= 1'b0;
            FRM_PRIO_O <= 3'h0;
            FRM_UPRIO_O <= 3'h0;
            FRM_MON_O <= 1'b0;
        end else begin
            FRM_VALID_O <= FRM_VALID_I;
            FRM_DROP_O <= FRM_VALID_I & drop_d;
            FRM_PRIO_O <= FRM_VALID_I ? prio_d : 3'h0;
            FRM_UPRIO_O <= FRM_VALID_I ? uprio_d : 3'h0;
            FRM_MON_O <= FRM_VALID_I & f_mir[PIC_MIR_RX] & MIRROR_GLOBAL_EN_I;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            TX_VALID_O <= 1'b0;
            TX_MON_O <= 1'b0;
        end else begin
            TX_VALID_O <= TX_VALID_I;
            TX_MON_O <= TX_VALID_I & t_mir[PIC_MIR_TX] & MIRROR_GLOBAL_EN_I;
        end
    end

    // ----------------------------------------
    // Mirroring port maps
    // ----------------------------------------
    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            SNIFF_PORTS_O <= 7'h00;
            RX_MON_PORTS_O <= 7'h00;
            TX_MON_PORTS_O <= 7'h00;
        end else begin
            for (int p = PIC_FIRST_PORT; p <= PIC_LAST_PORT; p++) begin
                SNIFF_PORTS_O[p-1] <= mir_q[p][PIC_MIR_SNIFF] & MIRROR_GLOBAL_EN_I;
                RX_MON_PORTS_O[p-1] <= mir_q[p][PIC_MIR_RX] & MIRROR_GLOBAL_EN_I;
                TX_MON_PORTS_O[p-1] <= mir_q[p][PIC_MIR_TX] & MIRROR_GLOBAL_EN_I;
            end
        end
    end
endmodule : pic_top

// [test/pic_top_properties.sv]
// Concurrent checks on the ports of the ingress control bank.
`timescale 1ns/1ps
module pic_top_chk (
    input wire logic CLK_I,
    input wire logic RSTN_I,
    input wire logic CYC_I,
    input wire logic STB_I,
    input wire logic [31:0] DAT_O,
    input wire logic ACK_O,
    input wire logic MIRROR_GLOBAL_EN_I,
    input wire logic FRM_VALID_I,
    input wire logic FRM_VALID_O,
    input wire logic FRM_DROP_O,
    input wire logic FRM_MON_O,
    input wire logic TX_VALID_I,
    input wire logic TX_VALID_O,
    input wire logic TX_MON_O,
    input wire logic [6:0] SNIFF_PORTS_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RSTN_I);
    AST_ACK_NEXT: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O) else $error("ack late");
    AST_ACK_PULSE: assert property (ACK_O |=> !ACK_O) else $error("ack too long");
    AST_ACK_CAUSE: assert property (ACK_O |-> $past(CYC_I && STB_I)) else $error("ack unasked");
    AST_DAT_HIGH: assert property (ACK_O |-> DAT_O[31:8] == 24'h000000) else $error("upper data set");
    AST_FRM_NEXT: assert property (FRM_VALID_I |=> FRM_VALID_O) else $error("frame result late");
    AST_FRM_CAUSE: assert property (FRM_VALID_O |-> $past(FRM_VALID_I)) else $error("frame unasked");
    AST_IDLE_ZERO: assert property (!FRM_VALID_O |-> !FRM_DROP_O && !FRM_MON_O) else $error("idle result");
    AST_TX_NEXT: assert property (TX_VALID_I |=> TX_VALID_O) else $error("tx result late");
    AST_MON_GLOBAL: assert property ((FRM_MON_O || TX_MON_O || SNIFF_PORTS_O != 7'h00)
        |-> $past(MIRROR_GLOBAL_EN_I)) else $error("mirror without global");
    COV_READ: cover property (ACK_O);
    COV_DROP: cover property (FRM_DROP_O);
    COV_TXMON: cover property (TX_MON_O);
endmodule : pic_top_chk
bind pic_top pic_top_chk u_chk (.CLK_I(CLK_I), .RSTN_I(RSTN_I), .CYC_I(CYC_I), .STB_I(STB_I), .DAT_O(DAT_O),
    .ACK_O(ACK_O), .MIRROR_GLOBAL_EN_I(MIRROR_GLOBAL_EN_I), .FRM_VALID_I(FRM_VALID_I), .FRM_VALID_O(FRM_VALID_O),
    .FRM_DROP_O(FRM_DROP_O), .FRM_MON_O(FRM_MON_O), .TX_VALID_I(TX_VALID_I), .TX_VALID_O(TX_VALID_O),
    .TX_MON_O(TX_MON_O), .SNIFF_PORTS_O(SNIFF_PORTS_O));

// [test/tb_top.sv]
// Self-checking bench for the ingress control bank.
`timescale 1ns/1ps
module tb_top;
    import pic_pkg::*;
    logic CLK_I = 0, RSTN_I = 0, CYC_I = 0, STB_I = 0, WE_I = 0, MIRROR_GLOBAL_EN_I = 0;
    logic [17:2] ADR_I = '0;
    logic [3:0] SEL_I = '0;
    logic [31:0] DAT_I = '0, DAT_O;
    logic FRM_VALID_I = 0, FRM_TAGGED_I = 0, TX_VALID_I = 0, ACK_O, FRM_VALID_O, FRM_DROP_O, FRM_MON_O;
    logic FRM_MAC_VLD_I = 1, FRM_VLAN_VLD_I = 1, FRM_DSCP_VLD_I = 1, FRM_ACL_VLD_I = 1, TX_VALID_O, TX_MON_O;
    logic [2:0] FRM_PORT_I = 0, FRM_UPRIO_I = 0, FRM_DEF_UPRIO_I = 2, TX_PORT_I = 0, FRM_PRIO_O, FRM_UPRIO_O;
    logic [2:0] FRM_MAC_PRIO_I = 1, FRM_VLAN_PRIO_I = 2, FRM_DSCP_PRIO_I = 4, FRM_ACL_PRIO_I = 3;
    logic [6:0] SNIFF_PORTS_O, RX_MON_PORTS_O, TX_MON_PORTS_O;
    logic [7:0] msk [3] = '{PIC_MIR_MASK, PIC_PRI_MASK, PIC_FLT_MASK};
    logic [7:0] pt [9] = '{8'h01, 8'h10, 8'h08, 8'h04, 8'h02, 8'h8A, 8'h4A, 8'h00, 8'h04};
    logic [2:0] pe [9] = '{3'h3, 3'h1, 3'h2, 3'h5, 3'h4, 3'h4, 3'h6, 3'h6, 3'h6};
    int err_count = 0, checks_done = 0;
    pic_top u_dut (.CLK_I(CLK_I), .RSTN_I(RSTN_I), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I),
        .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O), .MIRROR_GLOBAL_EN_I(MIRROR_GLOBAL_EN_I),
        .FRM_VALID_I(FRM_VALID_I), .FRM_PORT_I(FRM_PORT_I), .FRM_TAGGED_I(FRM_TAGGED_I), .FRM_UPRIO_I(FRM_UPRIO_I),
        .FRM_DEF_UPRIO_I(FRM_DEF_UPRIO_I), .FRM_MAC_VLD_I(FRM_MAC_VLD_I), .FRM_MAC_PRIO_I(FRM_MAC_PRIO_I),
        .FRM_VLAN_VLD_I(FRM_VLAN_VLD_I), .FRM_VLAN_PRIO_I(FRM_VLAN_PRIO_I), .FRM_DSCP_VLD_I(FRM_DSCP_VLD_I),
        .FRM_DSCP_PRIO_I(FRM_DSCP_PRIO_I), .FRM_ACL_VLD_I(FRM_ACL_VLD_I), .FRM_ACL_PRIO_I(FRM_ACL_PRIO_I),
        .TX_VALID_I(TX_VALID_I), .TX_PORT_I(TX_PORT_I), .FRM_VALID_O(FRM_VALID_O), .FRM_DROP_O(FRM_DROP_O),
        .FRM_PRIO_O(FRM_PRIO_O), .FRM_UPRIO_O(FRM_UPRIO_O), .FRM_MON_O(FRM_MON_O), .TX_VALID_O(TX_VALID_O),
        .TX_MON_O(TX_MON_O), .SNIFF_PORTS_O(SNIFF_PORTS_O), .RX_MON_PORTS_O(RX_MON_PORTS_O),
        .TX_MON_PORTS_O(TX_MON_PORTS_O));
    initial begin
        forever #2 CLK_I = ~CLK_I;
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            $display("CHECK FAILED %s expected %0h seen %0h", n, e, g);
            err_count++;
        end
    endtask : chk
    // Reads use the value present before the sampling edge, so data and ack are taken together.
    task automatic wb(input logic [3:0] p, input logic [11:0] i, input logic we, input logic [7:0] d,
                      output logic [31:0] r);
        int n;
        @(posedge CLK_I);
        CYC_I <= 1; STB_I <= 1; WE_I <= we; ADR_I <= {p, i}; SEL_I <= 4'h1; DAT_I <= {24'h000000, d};
        n = 0;
        do begin
            @(posedge CLK_I);
            n++;
        end while (ACK_O !== 1'b1);
        r = DAT_O;
        CYC_I <= 0; STB_I <= 0; WE_I <= 0;
        chk("ack cycles", 32'd2, n);
    endtask : wb
    task automatic wr(input logic [3:0] p, input logic [11:0] i, input logic [7:0] d);
        logic [31:0] r;
        wb(p, i, 1'b1, d, r);
    endtask : wr
    task automatic rd(input logic [3:0] p, input logic [11:0] i, input logic [7:0] e);
        logic [31:0] r;
        wb(p, i, 1'b0, 8'h00, r);
        chk("read", {24'h000000, e}, r);
    endtask : rd
    task automatic fr(input logic [2:0] p, input logic t, input logic [2:0] u);
        @(posedge CLK_I);
        FRM_VALID_I <= 1; FRM_PORT_I <= p; FRM_TAGGED_I <= t; FRM_UPRIO_I <= u;
        @(posedge CLK_I);
        FRM_VALID_I <= 0;
        @(posedge CLK_I);
        chk("frame valid", 32'h1, {31'h0, FRM_VALID_O});
    endtask : fr
    task automatic tx(input logic [2:0] p, input logic e);
        @(posedge CLK_I);
        TX_VALID_I <= 1; TX_PORT_I <= p;
        @(posedge CLK_I);
        TX_VALID_I <= 0;
        @(posedge CLK_I);
        chk("tx mon", {31'h0, e}, {31'h0, TX_MON_O & TX_VALID_O});
    endtask : tx
    task automatic report_and_stop();
        if (err_count == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        #40000;
        err_count++;
        report_and_stop();
    end
    initial begin
        repeat (2) @(posedge CLK_I);
        RSTN_I <= 1;
        for (int k = 0; k < 3; k++) rd(4'h1, PIC_IDX_MIRROR + 12'(k), 8'h00);
        for (int k = 0; k < 3; k++) begin
            wr(4'h3, PIC_IDX_MIRROR + 12'(k), 8'hFF);
            rd(4'h3, PIC_IDX_MIRROR + 12'(k), msk[k]);
        end
        rd(4'h4, 12'h800, 8'h00);
        wr(4'h0, 12'h801, 8'hFF);
        rd(4'h0, 12'h801, 8'h00);
        rd(4'h3, 12'h803, 8'h00);
        wr(4'h7, 12'h801, 8'h10);
        rd(4'h7, 12'h801, 8'h10);
        rd(4'h7, 12'h802, 8'h00);
        @(posedge CLK_I);
        MIRROR_GLOBAL_EN_I <= 1;
        repeat (2) @(posedge CLK_I);
        chk("maps", {11'h0, 7'h04, 7'h04, 7'h04}, {11'h0, SNIFF_PORTS_O, RX_MON_PORTS_O, TX_MON_PORTS_O});
        wr(4'h3, 12'h800, 8'h40);
        repeat (2) @(posedge CLK_I);
        chk("maps rx", {11'h0, 7'h00, 7'h04, 7'h00}, {11'h0, SNIFF_PORTS_O, RX_MON_PORTS_O, TX_MON_PORTS_O});
        fr(3'h3, 1'b1, 3'h0);
        chk("rx mon", 32'h1, {31'h0, FRM_MON_O});
        fr(3'h4, 1'b1, 3'h0);
        chk("rx mon other", 32'h0, {31'h0, FRM_MON_O});
        tx(3'h3, 1'b0);
        wr(4'h3, 12'h800, 8'h20);
        tx(3'h3, 1'b1);
        @(posedge CLK_I);
        MIRROR_GLOBAL_EN_I <= 0;
        tx(3'h3, 1'b0);
        chk("maps off", 32'h0, {11'h0, SNIFF_PORTS_O, RX_MON_PORTS_O, TX_MON_PORTS_O});
        wr(4'h3, 12'h801, 8'h00);
        wr(4'h3, 12'h802, 8'h10);
        fr(3'h3, 1'b0, 3'h0);
        chk("drop untagged", 32'h1, {31'h0, FRM_DROP_O});
        fr(3'h3, 1'b1, 3'h0);
        chk("keep tagged", 32'h0, {31'h0, FRM_DROP_O});
        wr(4'h3, 12'h802, 8'h08);
        fr(3'h3, 1'b1, 3'h0);
        chk("drop tagged", 32'h1, {31'h0, FRM_DROP_O});
        fr(3'h3, 1'b0, 3'h0);
        chk("keep untagged", 32'h0, {31'h0, FRM_DROP_O});
        wr(4'h3, 12'h802, 8'h80);
        fr(3'h3, 1'b1, 3'h6);
        chk("ceiling clamp", 32'h2, {29'h0, FRM_UPRIO_O});
        fr(3'h3, 1'b1, 3'h1);
        chk("ceiling pass", 32'h1, {29'h0, FRM_UPRIO_O});
        wr(4'h3, 12'h802, 8'h06);
        fr(3'h3, 1'b1, 3'h6);
        chk("no ceiling", 32'h6, {29'h0, FRM_UPRIO_O});
        for (int k = 0; k < 9; k++) begin
            wr(4'h3, 12'h801, pt[k]);
            fr(3'h3, k != 8, 3'h5);
            chk("prio", {29'h0, pe[k]}, {29'h0, FRM_PRIO_O});
        end
        FRM_VLAN_VLD_I <= 0;
        wr(4'h3, 12'h801, 8'h08);
        fr(3'h3, 1'b1, 3'h5);
        chk("prio no vlan result", 32'h6, {29'h0, FRM_PRIO_O});
        @(posedge CLK_I);
        RSTN_I <= 0;
        repeat (2) @(posedge CLK_I);
        RSTN_I <= 1;
        rd(4'h3, 12'h802, 8'h00);
        rd(4'h7, 12'h801, 8'h00);
        report_and_stop();
    end
endmodule : tb_top
